//--- fsw_consts.svh
// constants for the fault summary status word
`ifndef FSW_CONSTS_SVH
`define FSW_CONSTS_SVH

`define FSW_WORD_W 16
`define FSW_LOW_W 7
`define FSW_SRC_W 8
`define FSW_GRP_N 4
`define FSW_FRM_N 4
`define FSW_ADDR_W 8

`define FSW_BIT_RESTART 15
`define FSW_BIT_SUPPLY 14
`define FSW_BIT_CLOCK 13
`define FSW_BIT_LOGIC 12
`define FSW_BIT_OVERCURRENT 11
`define FSW_BIT_CHECK 10
`define FSW_BIT_TIMEOUT 9
`define FSW_BIT_EDGE 8
`define FSW_BIT_BADADDR 7

`define FSW_GRP_HI 14
`define FSW_GRP_LO 11
`define FSW_FRM_HI 10
`define FSW_FRM_LO 7

`define FSW_GRP_SUPPLY 3
`define FSW_GRP_CLOCK 2
`define FSW_GRP_LOGIC 1
`define FSW_GRP_OVERCURRENT 0
`define FSW_FRM_CHECK 3
`define FSW_FRM_TIMEOUT 2
`define FSW_FRM_EDGE 1
`define FSW_FRM_BADADDR 0

`define FSW_RST_RESTART 1'h0
`define FSW_RST_GRP 4'hf
`define FSW_RST_FRM 4'hf
`define FSW_RST_PENDING 4'h0
`define FSW_RST_LOW 7'h48
`define FSW_RST_UPPER 9'h0ff
`define FSW_ADDR_LIMIT 8'hff

`endif

//--- fsw_pkg.sv
// types and shared decoding for the fault summary status word
`default_nettype none
package fsw_pkg;
	`include "fsw_consts.svh"

	typedef logic [`FSW_SRC_W-1:0] fsw_src_t;

	typedef struct packed {
		logic [`FSW_GRP_N-1:0] flag_n;
	} fsw_sum_state_t;

	typedef struct packed {
		logic [`FSW_FRM_N-1:0] pending;
		logic [`FSW_FRM_N-1:0] shown_n;
	} fsw_frm_state_t;

	typedef struct packed {
		logic restart;
		logic [`FSW_WORD_W-1:0] word;
		logic [`FSW_FRM_N-1:0] seen;
	} fsw_top_state_t;

	// any source flag that is set and not masked
	function automatic logic fsw_any_active(input fsw_src_t flags, input fsw_src_t mask);
		fsw_any_active = |(flags & ~mask);
	endfunction : fsw_any_active

	function automatic logic fsw_bad_addr(input logic valid, input logic [`FSW_ADDR_W-1:0] addr);
		fsw_bad_addr = valid && (addr >= `FSW_ADDR_LIMIT);
	endfunction : fsw_bad_addr
endpackage : fsw_pkg
`default_nettype wire

//--- fsw_evt_if.sv
// events and flag bits passed between the status word and its helpers
`timescale 1ns/1ps
`default_nettype none
`include "fsw_consts.svh"
interface fsw_evt_if;
	import fsw_pkg::*;
	logic frame_start;
	logic [`FSW_FRM_N-1:0] frame_err;
	logic [`FSW_GRP_N-1:0] wr_clear;
	logic [`FSW_GRP_N-1:0] sum_n;
	logic [`FSW_FRM_N-1:0] frame_n;

	modport top(output frame_start, output frame_err, output wr_clear, input sum_n, input frame_n);
	modport summ(input wr_clear, output sum_n);
	modport frm(input frame_start, input frame_err, output frame_n);
endinterface : fsw_evt_if
`default_nettype wire

//--- fsw_alarm_summary.sv
// sticky active-low summaries of the four fault source groups
`timescale 1ns/1ps
`default_nettype none
`include "fsw_consts.svh"
module fsw_alarm_summary
	import fsw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire fsw_src_t [`FSW_GRP_N-1:0] flags,
	input wire fsw_src_t [`FSW_GRP_N-1:0] masks,
	fsw_evt_if.summ ev
);
	fsw_sum_state_t st_reg;
	fsw_sum_state_t st_next;
	logic [`FSW_GRP_N-1:0] active;

	genvar g;
	generate
		for (g = 0; g < `FSW_GRP_N; g++)
		begin : g_grp
			assign active[g] = fsw_any_active(flags[g], masks[g]);
		end
	endgenerate

	// an active source always wins over a write of one
	always_comb
	begin
		st_next = st_reg;
		for (int i = 0; i < `FSW_GRP_N; i++)
		begin
			if (active[i])
				st_next.flag_n[i] = 1'b0;
			else if (ev.wr_clear[i])
				st_next.flag_n[i] = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			st_reg.flag_n <= `FSW_RST_GRP;
		else
			st_reg <= st_next;
	end

	assign ev.sum_n = st_reg.flag_n;
endmodule : fsw_alarm_summary
`default_nettype wire

//--- fsw_frame_errors.sv
// per-frame serial error flags, shown during the frame after the fault
`timescale 1ns/1ps
`default_nettype none
`include "fsw_consts.svh"
module fsw_frame_errors
	import fsw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	fsw_evt_if.frm ev
);
	fsw_frm_state_t st_reg;
	fsw_frm_state_t st_next;

	// an error in the cycle of frame_start still belongs to the ending frame
	always_comb
	begin
		st_next = st_reg;
		if (ev.frame_start)
		begin
			st_next.shown_n = ~(st_reg.pending | ev.frame_err);
			st_next.pending = `FSW_RST_PENDING;
		end
		else
		begin
			st_next.pending = st_reg.pending | ev.frame_err;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_reg.pending <= `FSW_RST_PENDING;
			st_reg.shown_n <= `FSW_RST_FRM;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign ev.frame_n = st_reg.shown_n;
endmodule : fsw_frame_errors
`default_nettype wire

//--- fsw_fault_summary_word.sv
// fault summary status word: restart indicator, group summaries, frame errors
//
// Behaviour
// R1: restart indicator reads 0 after reset; writing one sets it back to 1.
// R2: supply summary low while unmasked supply flag set; write one restores once clear.
// R3: clock summary low while unmasked clock flag set; write one restores once clear.
// R4: logic summary low while unmasked digital flag set; write one restores once clear.
// R5: overcurrent summary low while unmasked comparator flag set; write one restores once clear.
// R6: checksum error of a frame shows low in the next frame, then returns high.
// R7: timeout of a frame shows low in the next frame, then returns high.
// R8: wrong serial edge count shows low in the next frame, then returns high.
// R9: access to address FFh or above shows low in the next frame.
// R10: all fault flags are active low and read 1 after reset.
// R11: zero writes and writes to per-frame flags change nothing.
`timescale 1ns/1ps
`default_nettype none
`include "fsw_consts.svh"
module fsw_fault_summary_word
	import fsw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [`FSW_SRC_W-1:0] supply_src_flags,
	input wire logic [`FSW_SRC_W-1:0] supply_src_mask,
	input wire logic [`FSW_SRC_W-1:0] clock_src_flags,
	input wire logic [`FSW_SRC_W-1:0] clock_src_mask,
	input wire logic [`FSW_SRC_W-1:0] logic_src_flags,
	input wire logic [`FSW_SRC_W-1:0] logic_src_mask,
	input wire logic [`FSW_SRC_W-1:0] overcurrent_source_flags,
	input wire logic [`FSW_SRC_W-1:0] overcurrent_src_mask,
	input wire logic frame_start,
	input wire logic frame_check_fail,
	input wire logic frame_timeout_fail,
	input wire logic frame_edge_fail,
	input wire logic reg_access_valid,
	input wire logic [`FSW_ADDR_W-1:0] reg_access_addr,
	input wire logic status_wr_en,
	input wire logic [`FSW_WORD_W-1:0] status_wr_data,
	input wire logic [`FSW_LOW_W-1:0] low_fields,
	output logic [`FSW_WORD_W-1:0] status_word,
	output logic restart_indicator_n,
	output logic supply_alarm_summary_n,
	output logic clock_alarm_summary_n,
	output logic logic_alarm_summary_n,
	output logic overcurrent_alarm_summary_n,
	output logic frame_check_error_n,
	output logic frame_timeout_error_n,
	output logic serial_edge_count_error_n,
	output logic bad_address_error_n
);
	fsw_top_state_t st_reg;
	fsw_top_state_t st_next;
	fsw_src_t [`FSW_GRP_N-1:0] grp_flags;
	fsw_src_t [`FSW_GRP_N-1:0] grp_masks;
	logic bad_access;
	logic restart_wr;
	logic [`FSW_WORD_W-1:0] word_live;

	fsw_evt_if ev ();

	assign grp_flags[`FSW_GRP_SUPPLY] = supply_src_flags;
	assign grp_flags[`FSW_GRP_CLOCK] = clock_src_flags;
	assign grp_flags[`FSW_GRP_LOGIC] = logic_src_flags;
	assign grp_flags[`FSW_GRP_OVERCURRENT] = overcurrent_source_flags;
	assign grp_masks[`FSW_GRP_SUPPLY] = supply_src_mask;
	assign grp_masks[`FSW_GRP_CLOCK] = clock_src_mask;
	assign grp_masks[`FSW_GRP_LOGIC] = logic_src_mask;
	assign grp_masks[`FSW_GRP_OVERCURRENT] = overcurrent_src_mask;

	// only the write-one-to-clear bits are passed on; bits 10..7 and zeros are dropped
	assign ev.wr_clear = status_wr_en ? status_wr_data[`FSW_GRP_HI:`FSW_GRP_LO] : `FSW_RST_PENDING; // see R11
	assign restart_wr = status_wr_en && status_wr_data[`FSW_BIT_RESTART]; // see R1

	assign bad_access = fsw_bad_addr(reg_access_valid, reg_access_addr); // see R9
	assign ev.frame_start = frame_start;
	assign ev.frame_err[`FSW_FRM_CHECK] = frame_check_fail; // see R6
	assign ev.frame_err[`FSW_FRM_TIMEOUT] = frame_timeout_fail; // see R7
	assign ev.frame_err[`FSW_FRM_EDGE] = frame_edge_fail; // see R8
	assign ev.frame_err[`FSW_FRM_BADADDR] = bad_access; // see R9

	fsw_alarm_summary u_summary (
		.clk(clk),
		.rst(rst),
		.flags(grp_flags),
		.masks(grp_masks),
		.ev(ev.summ)
	);

	fsw_frame_errors u_frame (
		.clk(clk),
		.rst(rst),
		.ev(ev.frm)
	);

	// the word as the helpers hold it now; bits 14..0 published one edge later
	always_comb
	begin
		word_live = {st_reg.restart, ev.sum_n, ev.frame_n, low_fields};
	end

	always_comb
	begin
		st_next = st_reg;
		if (restart_wr)
			st_next.restart = 1'b1; // see R1
		st_next.word = word_live;
		st_next.word[`FSW_BIT_RESTART] = st_next.restart;
		// errors seen since the last frame start, used only by the checks below
		if (frame_start)
			st_next.seen = `FSW_RST_PENDING;
		else
			st_next.seen = st_reg.seen | ev.frame_err;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_reg.restart <= `FSW_RST_RESTART; // see R1
			st_reg.word <= {`FSW_RST_UPPER, `FSW_RST_LOW}; // see R10
			st_reg.seen <= `FSW_RST_PENDING;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign status_word = st_reg.word;
	assign restart_indicator_n = st_reg.word[`FSW_BIT_RESTART];
	assign supply_alarm_summary_n = st_reg.word[`FSW_BIT_SUPPLY];
	assign clock_alarm_summary_n = st_reg.word[`FSW_BIT_CLOCK];
	assign logic_alarm_summary_n = st_reg.word[`FSW_BIT_LOGIC];
	assign overcurrent_alarm_summary_n = st_reg.word[`FSW_BIT_OVERCURRENT];
	assign frame_check_error_n = st_reg.word[`FSW_BIT_CHECK];
	assign frame_timeout_error_n = st_reg.word[`FSW_BIT_TIMEOUT];
	assign serial_edge_count_error_n = st_reg.word[`FSW_BIT_EDGE];
	assign bad_address_error_n = st_reg.word[`FSW_BIT_BADADDR];

	// restart indicator
	a_restart_after_reset: assert property (@(posedge clk) $fell(rst) |-> !st_reg.restart && !status_word[15]) // see R1
		else $error("restart indicator not low after reset");

	a_restart_stays_low: assert property (@(posedge clk) disable iff (rst)
		!st_reg.restart && !restart_wr |=> !st_reg.restart) // see R1
		else $error("restart indicator rose without a write of one");

	a_restart_write_one: assert property (@(posedge clk) disable iff (rst)
		restart_wr |=> st_reg.restart ##1 restart_indicator_n) // see R1
		else $error("write of one did not restore restart indicator");

	// group summaries
	a_supply_goes_low: assert property (@(posedge clk) disable iff (rst)
		fsw_any_active(supply_src_flags, supply_src_mask) |=> !ev.sum_n[3] ##1 !supply_alarm_summary_n) // see R2
		else $error("supply summary not low on unmasked flag");

	a_supply_sticky: assert property (@(posedge clk) disable iff (rst)
		!ev.sum_n[3] && !(status_wr_en && status_wr_data[14]) |=> !ev.sum_n[3]) // see R2
		else $error("supply summary rose without a write of one");

	a_supply_restore: assert property (@(posedge clk) disable iff (rst)
		status_wr_en && status_wr_data[14] && !fsw_any_active(supply_src_flags, supply_src_mask)
		|=> ev.sum_n[3]) // see R2
		else $error("supply summary not restored by write of one");

	a_clock_goes_low: assert property (@(posedge clk) disable iff (rst)
		fsw_any_active(clock_src_flags, clock_src_mask) |=> !ev.sum_n[2] ##1 !clock_alarm_summary_n) // see R3
		else $error("clock summary not low on unmasked flag");

	a_clock_restore: assert property (@(posedge clk) disable iff (rst)
		status_wr_en && status_wr_data[13] && !fsw_any_active(clock_src_flags, clock_src_mask)
		|=> ev.sum_n[2]) // see R3
		else $error("clock summary not restored by write of one");

	a_logic_goes_low: assert property (@(posedge clk) disable iff (rst)
		fsw_any_active(logic_src_flags, logic_src_mask) |=> !ev.sum_n[1] ##1 !logic_alarm_summary_n) // see R4
		else $error("logic summary not low on unmasked flag");

	a_logic_sticky: assert property (@(posedge clk) disable iff (rst)
		!ev.sum_n[1] && !(status_wr_en && status_wr_data[12]) |=> !ev.sum_n[1]) // see R4
		else $error("logic summary rose without a write of one");

	a_overcurrent_low: assert property (@(posedge clk) disable iff (rst)
		fsw_any_active(overcurrent_source_flags, overcurrent_src_mask)
		|=> !ev.sum_n[0] ##1 !overcurrent_alarm_summary_n) // see R5
		else $error("overcurrent summary not low on unmasked flag");

	a_overcurrent_restore: assert property (@(posedge clk) disable iff (rst)
		status_wr_en && status_wr_data[11]
		&& !fsw_any_active(overcurrent_source_flags, overcurrent_src_mask) |=> ev.sum_n[0]) // see R5
		else $error("overcurrent summary not restored by write of one");

	// per-frame errors
	a_check_next_frame: assert property (@(posedge clk) disable iff (rst)
		frame_start |=> ev.frame_n[3] == !$past(st_reg.seen[3] || frame_check_fail)) // see R6
		else $error("checksum error flag wrong at frame start");

	a_timeout_next_frame: assert property (@(posedge clk) disable iff (rst)
		frame_start |=> ev.frame_n[2] == !$past(st_reg.seen[2] || frame_timeout_fail)) // see R7
		else $error("timeout error flag wrong at frame start");

	a_edge_next_frame: assert property (@(posedge clk) disable iff (rst)
		frame_start |=> ev.frame_n[1] == !$past(st_reg.seen[1] || frame_edge_fail)) // see R8
		else $error("edge count error flag wrong at frame start");

	a_badaddr_next_frame: assert property (@(posedge clk) disable iff (rst)
		frame_start && (st_reg.seen[0] || (reg_access_valid && reg_access_addr == 8'hff))
		|=> !ev.frame_n[0] ##1 !bad_address_error_n) // see R9
		else $error("bad address flag not low in following frame");

	a_frame_flags_hold: assert property (@(posedge clk) disable iff (rst)
		!frame_start |=> $stable(ev.frame_n)) // see R11
		else $error("frame error flags changed inside a frame");

	// reset values, ignored writes and the registered word
	a_flags_reset_high: assert property (@(posedge clk) $fell(rst) |-> status_word[15:7] == 9'h0ff
		&& ev.sum_n == 4'hf && ev.frame_n == 4'hf) // see R10
		else $error("fault flags not at no-fault value after reset");

	a_zero_write_ignored: assert property (@(posedge clk) disable iff (rst)
		status_wr_en && status_wr_data[14:11] == 4'h0 && ev.sum_n == 4'hf
		&& !fsw_any_active(supply_src_flags, supply_src_mask) |=> ev.sum_n[3]) // see R11
		else $error("zero write disturbed a summary flag");

	a_word_follows: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> status_word[14:0] == $past(word_live[14:0])) // see R10
		else $error("status word does not follow its flags");
endmodule : fsw_fault_summary_word
`default_nettype wire

//--- fsw_host_model.sv
// host-side model that drives serial frame events into the status word
`timescale 1ns/1ps
`default_nettype none
module fsw_host_model (
	output logic frame_start,
	output logic frame_check_fail,
	output logic frame_timeout_fail,
	output logic frame_edge_fail,
	output logic reg_access_valid,
	output logic [7:0] reg_access_addr,
	input wire logic clk
);
	initial
	begin
		frame_start = 1'b0;
		{frame_check_fail, frame_timeout_fail, frame_edge_fail} = 3'h0;
		reg_access_valid = 1'b0;
		reg_access_addr = 8'h5a;
	end

	// one-cycle pulse that opens a new frame
	task automatic start_frame();
		@(posedge clk);
		#1;
		frame_start = 1'b1;
		@(posedge clk);
		#1;
		frame_start = 1'b0;
	endtask : start_frame

	// error pulses and one register access inside the current frame
	task automatic fault(input logic [2:0] err, input logic [7:0] addr);
		@(posedge clk);
		#1;
		{frame_check_fail, frame_timeout_fail, frame_edge_fail} = err;
		reg_access_valid = 1'b1;
		reg_access_addr = addr;
		@(posedge clk);
		#1;
		{frame_check_fail, frame_timeout_fail, frame_edge_fail} = 3'h0;
		reg_access_valid = 1'b0;
		// an idle address must not keep showing the last value
		reg_access_addr = ~addr;
	endtask : fault
endmodule : fsw_host_model
`default_nettype wire

//--- fsw_fault_summary_word_tb_top.sv
// self-checking testbench for the fault summary status word
`timescale 1ns/1ps
`default_nettype none
module fsw_fault_summary_word_tb_top;
	import fsw_pkg::*;
	logic clk;
	logic rst;
	logic [7:0] sf [4];
	logic [7:0] sm [4];
	logic fs, fcf, ftf, fef, rav, wr_en;
	logic [7:0] raa;
	logic [15:0] wr_data, status_word, exp_w;
	logic [6:0] low_fields;
	logic [8:0] nvec;
	int errors, total_checks;

	fsw_fault_summary_word i_dut (.clk(clk), .rst(rst), .supply_src_flags(sf[0]), .supply_src_mask(sm[0]),
		.clock_src_flags(sf[1]), .clock_src_mask(sm[1]), .logic_src_flags(sf[2]), .logic_src_mask(sm[2]),
		.overcurrent_source_flags(sf[3]), .overcurrent_src_mask(sm[3]), .frame_start(fs),
		.frame_check_fail(fcf), .frame_timeout_fail(ftf), .frame_edge_fail(fef), .reg_access_valid(rav),
		.reg_access_addr(raa), .status_wr_en(wr_en), .status_wr_data(wr_data), .low_fields(low_fields),
		.status_word(status_word), .restart_indicator_n(nvec[8]), .supply_alarm_summary_n(nvec[7]),
		.clock_alarm_summary_n(nvec[6]), .logic_alarm_summary_n(nvec[5]), .overcurrent_alarm_summary_n(nvec[4]),
		.frame_check_error_n(nvec[3]), .frame_timeout_error_n(nvec[2]), .serial_edge_count_error_n(nvec[1]),
		.bad_address_error_n(nvec[0]));

	fsw_host_model i_host (.frame_start(fs), .frame_check_fail(fcf), .frame_timeout_fail(ftf),
		.frame_edge_fail(fef), .reg_access_valid(rav), .reg_access_addr(raa), .clk(clk));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("FAIL %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	// one-cycle write; the word shows it two edges after the request, bit 15 one edge after
	task automatic wr(input logic [15:0] d);
		@(posedge clk);
		#1;
		wr_en = 1'b1;
		wr_data = d;
		@(posedge clk);
		#1;
		wr_en = 1'b0;
		wr_data = ~d;
		@(posedge clk);
		#1;
	endtask : wr

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	task automatic t_reset();
		rst = 1'b1;
		repeat (12) @(posedge clk);
		#1;
		chk(status_word, 16'h7fc8, "word during reset");
		rst = 1'b0;
		@(posedge clk);
		#1;
		chk({7'h0, status_word[15:7]}, {7'h0, 9'h0ff}, "word after reset");
		chk({7'h0, nvec}, {7'h0, 9'h0ff}, "flag outputs after reset");
		$display("test reset done");
	endtask : t_reset

	task automatic t_restart();
		low_fields = 7'h35;
		exp_w = 16'h7fb5;
		wr(16'h7fff);
		chk(status_word, exp_w, "restart held without bit 15");
		wr(16'h8000);
		exp_w[15] = 1'b1;
		chk(status_word, exp_w, "restart indicator written back");
		$display("test restart done");
	endtask : t_restart

	task automatic t_groups();
		int g;
		for (g = 0; g < 4; g++)
		begin
			sf[g] = 8'h10;
			sm[g] = 8'h10;
			settle();
			chk(status_word, exp_w, "masked flag ignored");
			sf[g] = 8'h11;
			settle();
			exp_w[14-g] = 1'b0;
			chk(status_word, exp_w, "summary low on unmasked flag");
			wr(16'h7800);
			chk(status_word, exp_w, "write one while flag set");
			sf[g] = 8'h00;
			settle();
			chk(status_word, exp_w, "summary sticky after clear");
			wr(16'h0000);
			chk(status_word, exp_w, "zero write keeps summary");
			wr(16'h8000 >> (g + 1));
			exp_w[14-g] = 1'b1;
			chk(status_word, exp_w, "summary restored by write one");
		end
		$display("test groups done");
	endtask : t_groups

	task automatic t_frames();
		logic [2:0] errs [5] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h0};
		logic [7:0] addrs [5] = '{8'h10, 8'h20, 8'h30, 8'hff, 8'hfe};
		logic [3:0] hit [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0};
		logic [15:0] e;
		int i;
		i_host.start_frame();
		for (i = 0; i < 5; i++)
		begin
			i_host.fault(errs[i], addrs[i]);
			i_host.start_frame();
			@(posedge clk);
			#1;
			e = {exp_w[15:11], ~hit[i], exp_w[6:0]};
			chk(status_word, e, "frame error in next frame");
			chk({7'h0, nvec}, {7'h0, e[15:7]}, "frame error outputs");
			wr(16'h0780);
			chk(status_word, e, "write ignored on frame flags");
			i_host.start_frame();
			@(posedge clk);
			#1;
			chk(status_word, exp_w, "frame flag cleared by new frame");
		end
		$display("test frames done");
	endtask : t_frames

	initial
	begin
		errors = 0;
		total_checks = 0;
		rst = 1'b1;
		wr_en = 1'b0;
		wr_data = 16'h0000;
		low_fields = 7'h48;
		for (int k = 0; k < 4; k++)
		begin
			sf[k] = 8'h00;
			sm[k] = 8'h00;
		end
		t_reset();
		t_restart();
		t_groups();
		t_frames();
		t_reset();
		results();
	end

	initial
	begin
		#200000;
		errors++;
		$display("FAIL %0t: watchdog expired", $time);
		results();
	end
endmodule : fsw_fault_summary_word_tb_top
`default_nettype wire
